// ===== bwl_loader.sv
// Byte-wide configuration loader: master parallel up/down and synchronous peripheral modes.
// Assumes the configuration core drains bytes, and reports load end, clock speed and 22-line requests.
`timescale 1ns/1ps
module bwl_loader
	import bwl_pkg::*;
#(
	parameter logic ALWAYS_22 = 1'b0
) (
	// Clocks and reset
	input wire logic clk_sys_in,
	input wire logic rst_n_in,
	input wire logic cfg_clk_in,
	// Configuration pins
	input wire logic [2:0] mode_select_pins_in,
	input wire logic [7:0] prom_data_in,
	output logic config_clock_out,
	output logic config_clock_oe_out,
	output logic [LOW_ADDR_W-1:0] prom_addr_out,
	output logic [3:0] upper_address_lines_out,
	output logic upper_address_lines_oe_out,
	output logic prom_read_strobe_n_out,
	output logic serial_pass_out,
	output logic byte_acknowledge_out,
	output logic byte_acknowledge_oe_out,
	// Configuration core side
	input wire logic init_done_in,
	input wire logic addr22_req_in,
	input wire logic fast_clk_req_in,
	input wire logic load_done_in,
	output logic [7:0] cfg_byte_out,
	output logic cfg_byte_valid_out,
	input wire logic cfg_byte_ready_in,
	output logic overrun_out
);

	// ----------------------------------------------------------------
	// System domain state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [2:0] mode_s1;
		logic [2:0] mode_s2;
		logic [7:0] data_s1;
		logic [7:0] data_s2;
		logic [1:0] settle;
		logic [2:0] mode;
		logic mode_ok;
		logic per;
		bwl_mst_t st;
		logic [DIV_W-1:0] div;
		logic config_clock;
		logic fast;
		logic en22;
		logic [BIT_CNT_W-1:0] bitc;
		logic [ADDR_W-1:0] addr;
		logic rd_act;
		logic [7:0] stage;
		logic [1:0] pend;
		logic [7:0] sh;
		logic sdo;
		logic tg1;
		logic tg2;
		logic tg3;
		logic push_v;
		logic [7:0] push_data;
		logic overrun;
	} bwl_sys_st_t;

	// Link domain state, rising and falling edge parts
	typedef struct packed {
		logic per_s1;
		logic per_s2;
		logic init_s1;
		logic init_s2;
		logic [BIT_CNT_W-1:0] bitc;
		logic ack;
		logic [1:0][7:0] hold;
		logic tog;
	} bwl_lnk_st_t;

	typedef struct packed {
		logic seen;
		logic pend;
		logic [7:0] sh;
		logic sdo;
	} bwl_neg_st_t;

	bwl_sys_st_t sq;
	bwl_sys_st_t sd;
	bwl_lnk_st_t lq;
	bwl_lnk_st_t ld;
	bwl_neg_st_t nq;
	bwl_neg_st_t nd;
	logic rst1_q;
	logic rst2_q;
	logic lrst1_q;
	logic lrst2_q;
	logic cap;
	logic rise;
	logic fall;
	logic cap_l;
	logic is_up;
	logic is_master;
	logic mst_active;
	logic [DIV_W-1:0] half_last;

	bwl_stream_if buf_in_if ();
	bwl_stream_if buf_out_if ();

	// ----------------------------------------------------------------
	// Reset release, one synchroniser per domain
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rst1_q <= 1'b0;
			rst2_q <= 1'b0;
		end else begin
			rst1_q <= 1'b1;
			rst2_q <= rst1_q;
		end
	end

	// Link reset; the link clock may stop, so release can lag until it runs
	always_ff @(posedge cfg_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			lrst1_q <= 1'b0;
			lrst2_q <= 1'b0;
		end else begin
			lrst1_q <= 1'b1;
			lrst2_q <= lrst1_q;
		end
	end

	// ----------------------------------------------------------------
	// Master sequencer, clock divider and serialiser
	// ----------------------------------------------------------------
	assign is_up = (sq.mode == MODE_PAR_UP);
	assign is_master = is_up || (sq.mode == MODE_PAR_DN);
	assign mst_active = (sq.st == ST_FIRST) || (sq.st == ST_RUN);
	assign half_last = sq.fast ? HALF_FAST_LAST : HALF_SLOW_LAST;

	// Step address with wrap at 18 or 22 bits
	function automatic logic [ADDR_W-1:0] bwl_step(input logic [ADDR_W-1:0] a, input logic up, input logic w22);
		logic [ADDR_W-1:0] n;
		n = up ? ADDR_W'(a + ADDR_ONE) : ADDR_W'(a - ADDR_ONE);
		return w22 ? n : (n & ADDR_MASK18);
	endfunction : bwl_step

	always_comb begin
		sd = sq;
		cap = 1'b0;
		rise = 1'b0;
		fall = 1'b0;
		sd.mode_s1 = mode_select_pins_in;
		sd.mode_s2 = sq.mode_s1;
		sd.data_s1 = prom_data_in;
		sd.data_s2 = sq.data_s1;
		sd.tg1 = lq.tog;
		sd.tg2 = sq.tg1;
		sd.tg3 = sq.tg2;
		sd.push_v = 1'b0;
		// Mode pins latched once, before any loading starts
		if (!sq.mode_ok) begin
			if (sq.settle == SETTLE_LAST) begin
				sd.mode = sq.mode_s2;
				sd.mode_ok = 1'b1;
				sd.per = (sq.mode_s2 == MODE_SYNC_PER);
			end else begin
				sd.settle = sq.settle + SETTLE_ONE;
			end
		end
		// Sticky 22-line enable; the fixed variant ignores an 18-line choice
		if (addr22_req_in || ALWAYS_22) begin
			sd.en22 = 1'b1;
		end
		unique case (sq.st)
			ST_IDLE: begin
				if (sq.mode_ok && is_master) begin
					sd.st = ST_FIRST;
					sd.div = DIV_ZERO;
					sd.rd_act = 1'b1;
					if (is_up) begin
						sd.addr = ADDR_UP_START;
					end else begin
						sd.addr = sd.en22 ? ADDR_DN_START22 : ADDR_DN_START18;
					end
				end
			end
			ST_FIRST: begin
				// Clock held low through the first strobe cycle
				if (sq.div == FIRST_STROBE_LAST) begin
					if (buf_in_if.ready) begin
						cap = 1'b1;
						sd.config_clock = 1'b1;
						sd.st = ST_RUN;
						sd.div = DIV_ZERO;
						sd.rd_act = 1'b0;
					end
				end else begin
					sd.div = sq.div + DIV_ONE;
				end
			end
			ST_RUN: begin
				if (sq.fast == 1'b0 && fast_clk_req_in) begin
					sd.fast = 1'b1;
				end
				if (load_done_in) begin
					sd.st = ST_DONE;
					sd.rd_act = 1'b0;
				end else if (sq.div >= half_last) begin
					sd.div = DIV_ZERO;
					if (!sq.config_clock) begin
						// A full buffer stretches the clock rather than dropping a byte
						if (sq.bitc == BIT_LAST && !buf_in_if.ready) begin
							sd.div = sq.div;
						end else begin
							rise = 1'b1;
							sd.config_clock = 1'b1;
							sd.bitc = sq.bitc + BIT_ONE;
							cap = (sq.bitc == BIT_LAST);
							sd.rd_act = (sq.bitc == BIT_PRE_LAST);
						end
					end else begin
						fall = 1'b1;
						sd.config_clock = 1'b0;
					end
				end else begin
					sd.div = sq.div + DIV_ONE;
				end
			end
			ST_DONE: begin
				sd.config_clock = sq.config_clock;
			end
		endcase
		// Byte capture, then the address moves on
		if (cap) begin
			sd.stage = sq.data_s2;
			sd.pend = PEND_START;
			sd.push_v = 1'b1;
			sd.push_data = sq.data_s2;
			sd.addr = bwl_step(sq.addr, is_up, sq.en22);
		end
		// Output bit moves on falling edges; LSB on the second one after capture
		if (fall) begin
			if (sq.pend == PEND_LOAD) begin
				sd.sh = sq.stage;
				sd.sdo = sq.stage[0];
				sd.pend = PEND_NONE;
			end else begin
				sd.sdo = sq.sh[1];
				sd.sh = sq.sh >> 1;
				if (sq.pend == PEND_START) begin
					sd.pend = PEND_LOAD;
				end
			end
		end
		// Peripheral byte arrives as a toggle; two hold slots keep each word still for sixteen link edges
		if (sq.tg2 != sq.tg3) begin
			sd.push_v = 1'b1;
			sd.push_data = lq.hold[sq.tg2];
		end
		// External clock cannot be stalled, so a refused byte is only flagged
		if (sq.push_v && !buf_in_if.ready) begin
			sd.overrun = 1'b1;
		end
	end

	always_ff @(posedge clk_sys_in or negedge rst2_q) begin
		if (!rst2_q) begin
			sq <= '0;
			sq.st <= ST_IDLE;
		end else begin
			sq <= sd;
		end
	end

	// ----------------------------------------------------------------
	// Link domain: peripheral capture and acknowledge
	// ----------------------------------------------------------------
	assign cap_l = lq.per_s2 && (lq.bitc == BIT_ZERO);

	always_comb begin
		ld = lq;
		ld.per_s1 = sq.per;
		ld.per_s2 = lq.per_s1;
		ld.init_s1 = init_done_in;
		ld.init_s2 = lq.init_s1;
		ld.ack = cap_l;
		ld.bitc = lq.per_s2 ? lq.bitc + BIT_ONE : BIT_ZERO;
		if (cap_l) begin
			ld.hold[~lq.tog] = prom_data_in;
			ld.tog = ~lq.tog;
		end
	end

	always_ff @(posedge cfg_clk_in or negedge lrst2_q) begin
		if (!lrst2_q) begin
			lq <= '0;
		end else begin
			lq <= ld;
		end
	end

	// Falling-edge serialiser: first fall notes the byte, second shows its LSB
	always_comb begin
		nd = nq;
		if (lq.tog != nq.seen) begin
			nd.seen = lq.tog;
			nd.pend = 1'b1;
			nd.sdo = nq.sh[1];
			nd.sh = nq.sh >> 1;
		end else if (nq.pend) begin
			nd.pend = 1'b0;
			nd.sh = lq.hold[lq.tog];
			nd.sdo = lq.hold[lq.tog][0];
		end else begin
			nd.sdo = nq.sh[1];
			nd.sh = nq.sh >> 1;
		end
	end

	always_ff @(negedge cfg_clk_in or negedge lrst2_q) begin
		if (!lrst2_q) begin
			nq <= '0;
		end else begin
			nq <= nd;
		end
	end

	// ----------------------------------------------------------------
	// Byte buffer toward the configuration core
	// ----------------------------------------------------------------
	assign buf_in_if.data = sq.push_data;
	assign buf_in_if.valid = sq.push_v;
	assign buf_out_if.ready = cfg_byte_ready_in;

	bwl_fifo #(
		.DATA_W(BYTE_W),
		.DEPTH(BUF_DEPTH),
		.PTR_W(1)
	) u_fifo (
		.clk_in(clk_sys_in),
		.rst_n_in(rst2_q),
		.fill(buf_in_if),
		.drain(buf_out_if)
	);

	// ----------------------------------------------------------------
	// Pin and core outputs
	// ----------------------------------------------------------------
	assign config_clock_out = sq.config_clock;
	assign config_clock_oe_out = mst_active;
	assign prom_addr_out = sq.addr[LOW_ADDR_W-1:0];
	assign upper_address_lines_out = sq.addr[ADDR_W-1:LOW_ADDR_W];
	assign upper_address_lines_oe_out = mst_active && sq.en22;
	assign prom_read_strobe_n_out = ~sq.rd_act;
	assign serial_pass_out = sq.per ? nq.sdo : sq.sdo;
	assign byte_acknowledge_out = lq.ack;
	assign byte_acknowledge_oe_out = lq.init_s2 && lq.per_s2;
	assign cfg_byte_out = buf_out_if.data;
	assign cfg_byte_valid_out = buf_out_if.valid;
	assign overrun_out = sq.overrun;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	sequence bwl_first_cap;
		$rose(sq.st == ST_RUN);
	endsequence

	addr_start_up_a: assert property (@(posedge clk_sys_in) disable iff (!rst2_q)
		$rose(sq.st == ST_FIRST) && is_up |-> sq.addr == ADDR_UP_START) else $error("up start address wrong");
	addr_start_dn_a: assert property (@(posedge clk_sys_in) disable iff (!rst2_q)
		$rose(sq.st == ST_FIRST) && !is_up && !sq.en22 |-> sq.addr == ADDR_DN_START18) else $error("down start wrong");
	addr_step_a: assert property (@(posedge clk_sys_in) disable iff (!rst2_q)
		cap && !sq.en22 |=> sq.addr == bwl_step($past(sq.addr), is_up, 1'b0)) else $error("address step wrong");
	strobe_cap_a: assert property (@(posedge clk_sys_in) disable iff (!rst2_q)
		cap |-> sq.rd_act && !sq.config_clock) else $error("capture outside strobe");
	clk_start_a: assert property (@(posedge clk_sys_in) disable iff (!rst2_q)
		bwl_first_cap |-> sq.config_clock && $past(sq.st == ST_FIRST)) else $error("clock start wrong");
	lsb_delay_a: assert property (@(posedge clk_sys_in) disable iff (!rst2_q)
		fall && sq.pend == PEND_LOAD |=> sq.sdo == $past(sq.stage[0])) else $error("lsb late");
	dout_fall_a: assert property (@(posedge clk_sys_in) disable iff (!rst2_q)
		$changed(sq.sdo) |-> $past(fall)) else $error("pass-out moved off falling edge");
	upper_idle_a: assert property (@(posedge clk_sys_in) disable iff (!rst2_q)
		!sq.en22 |-> !upper_address_lines_oe_out) else $error("upper lines driven early");
	wrap18_a: assert property (@(posedge clk_sys_in) disable iff (!rst2_q)
		cap && is_up && !sq.en22 && sq.addr == ADDR_MASK18 |=> sq.addr == ADDR_UP_START) else $error("no wrap");
	every8_a: assert property (@(posedge cfg_clk_in) disable iff (!lrst2_q)
		cap_l |=> (!cap_l) [*7]) else $error("capture spacing wrong");
	ack_pulse_a: assert property (@(posedge cfg_clk_in) disable iff (!lrst2_q)
		cap_l |=> lq.ack ##1 !lq.ack) else $error("acknowledge width wrong");
	ack_float_a: assert property (@(posedge cfg_clk_in) disable iff (!lrst2_q)
		!lq.init_s2 |-> !byte_acknowledge_oe_out) else $error("acknowledge driven before init");

endmodule : bwl_loader

// ===== bwl_pkg.sv
// Constants, mode codes and state encodings for the byte-wide configuration loader.
// Assumes a 25 MHz system clock; the link clock is supplied from outside in peripheral mode.
package bwl_pkg;

	// ----------------------------------------------------------------
	// Clock and timing
	// ----------------------------------------------------------------
	localparam int SYS_CLK_NS = 40;
	localparam int CONFIG_CLOCK_SLOW_NS = 1000;
	localparam int CONFIG_CLOCK_FAST_NS = 125;
	localparam int DIV_W = 5;
	// Slow half period rounds down; the fast one rounds up, since one cycle per half would overrun
	// the clock tolerance and leave the two-flop data path no time before the capture edge
	localparam int HALF_SLOW_INT = (CONFIG_CLOCK_SLOW_NS / 2) / SYS_CLK_NS;
	localparam int HALF_FAST_INT = (CONFIG_CLOCK_FAST_NS + 2 * SYS_CLK_NS - 1) / (2 * SYS_CLK_NS);
	localparam logic [DIV_W-1:0] HALF_SLOW_LAST = DIV_W'(HALF_SLOW_INT - 1);
	localparam logic [DIV_W-1:0] HALF_FAST_LAST = DIV_W'(HALF_FAST_INT - 1);
	localparam logic [DIV_W-1:0] FIRST_STROBE_LAST = DIV_W'(2 * HALF_SLOW_INT - 1);
	localparam logic [DIV_W-1:0] DIV_ZERO = 5'h00;
	localparam logic [DIV_W-1:0] DIV_ONE = 5'h01;

	// ----------------------------------------------------------------
	// Mode pin codes
	// ----------------------------------------------------------------
	localparam logic [2:0] MODE_PAR_UP = 3'h4;
	localparam logic [2:0] MODE_PAR_DN = 3'h6;
	localparam logic [2:0] MODE_SYNC_PER = 3'h3;
	localparam logic [1:0] SETTLE_LAST = 2'h3;
	localparam logic [1:0] SETTLE_ONE = 2'h1;

	// ----------------------------------------------------------------
	// Address counter
	// ----------------------------------------------------------------
	localparam int ADDR_W = 22;
	localparam int LOW_ADDR_W = 18;
	localparam logic [ADDR_W-1:0] ADDR_UP_START = 22'h000000;
	localparam logic [ADDR_W-1:0] ADDR_DN_START18 = 22'h03ffff;
	localparam logic [ADDR_W-1:0] ADDR_DN_START22 = 22'h3fffff;
	localparam logic [ADDR_W-1:0] ADDR_MASK18 = 22'h03ffff;
	localparam logic [ADDR_W-1:0] ADDR_ONE = 22'h000001;

	// ----------------------------------------------------------------
	// Byte serialisation
	// ----------------------------------------------------------------
	localparam int BYTE_W = 8;
	localparam int BIT_CNT_W = 3;
	localparam logic [BIT_CNT_W-1:0] BIT_ZERO = 3'h0;
	localparam logic [BIT_CNT_W-1:0] BIT_ONE = 3'h1;
	localparam logic [BIT_CNT_W-1:0] BIT_LAST = 3'h7;
	localparam logic [BIT_CNT_W-1:0] BIT_PRE_LAST = 3'h6;
	// Falling edges between capture and the first bit of the byte
	localparam logic [1:0] PEND_START = 2'h2;
	localparam logic [1:0] PEND_LOAD = 2'h1;
	localparam logic [1:0] PEND_NONE = 2'h0;
	localparam int BUF_DEPTH = 2;

	// ----------------------------------------------------------------
	// Master sequencer states
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_FIRST = 4'h2,
		ST_RUN = 4'h4,
		ST_DONE = 4'h8
	} bwl_mst_t;

endpackage : bwl_pkg

// ===== bwl_stream_if.sv
// Valid/ready byte stream between the loader and its buffer.
// Assumes both ends share the system clock.
`timescale 1ns/1ps
interface bwl_stream_if;
	logic [7:0] data;
	logic valid;
	logic ready;
	modport src (output data, output valid, input ready);
	modport snk (input data, input valid, output ready);
endinterface : bwl_stream_if

// ===== bwl_fifo.sv
// Small flip-flop FIFO with valid/ready on both sides.
// Assumes DEPTH is a power of two so the pointers wrap naturally.
`timescale 1ns/1ps
module bwl_fifo
	import bwl_pkg::*;
#(
	parameter int DATA_W = 8,
	parameter int DEPTH = 2,
	parameter int PTR_W = 1
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// Stream sides
	bwl_stream_if.snk fill,
	bwl_stream_if.src drain
);

	typedef struct packed {
		logic [DEPTH-1:0][DATA_W-1:0] mem;
		logic [PTR_W-1:0] wp;
		logic [PTR_W-1:0] rp;
		logic [PTR_W:0] cnt;
	} bwl_fifo_st_t;

	localparam logic [PTR_W:0] CNT_FULL = (PTR_W + 1)'(DEPTH);
	localparam logic [PTR_W:0] CNT_ONE = (PTR_W + 1)'(1);
	localparam logic [PTR_W-1:0] PTR_ONE = PTR_W'(1);

	bwl_fifo_st_t q;
	bwl_fifo_st_t d;
	logic push;
	logic pop;

	// Honest flags: full refuses the filler, empty hides stale data
	assign fill.ready = (q.cnt != CNT_FULL);
	assign drain.valid = (q.cnt != '0);
	assign drain.data = q.mem[q.rp];
	assign push = fill.valid && fill.ready;
	assign pop = drain.valid && drain.ready;

	// Next state
	always_comb begin
		d = q;
		if (push) begin
			d.mem[q.wp] = fill.data;
			d.wp = q.wp + PTR_ONE;
		end
		if (pop) begin
			d.rp = q.rp + PTR_ONE;
		end
		if (push && !pop) begin
			d.cnt = q.cnt + CNT_ONE;
		end else if (pop && !push) begin
			d.cnt = q.cnt - CNT_ONE;
		end
	end

	// State register
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	fifo_bound_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(q.cnt == CNT_FULL && !pop) |=> q.cnt == CNT_FULL) else $error("fifo lost an entry while full");

endmodule : bwl_fifo

// ===== bwl_partner.sv
// Far-side model: byte-wide memory for the master tests, clocked byte source for the peripheral test.
// Assumes the bench raises run_in only in peripheral mode, after the mode pins are latched.
`timescale 1ns/1ps
module bwl_partner
	import bwl_pkg::*;
(
	// Memory side
	input wire logic [LOW_ADDR_W-1:0] addr_in,
	input wire logic strobe_n_in,
	// Source side
	input wire logic run_in,
	input wire logic ack_in,
	output logic cfg_clk_out,
	output logic [7:0] data_out
);
	// --------------------
	// Memory and source
	// --------------------
	localparam int N_BYTES = 5;
	// Ten trailing rises plus one for the single chained device the bench models
	localparam int TAIL_RISES = 11;
	int idx = 0;
	int tail = 0;
	logic [7:0] mem_q = 8'h00;
	initial cfg_clk_out = 1'b0;
	// Link clock runs only in a frame and always parks low, never mid-phase
	always begin
		#6;
		if ((run_in && tail < TAIL_RISES) || cfg_clk_out) begin
			cfg_clk_out = ~cfg_clk_out;
		end
	end
	// Memory answers while read; once released it shows the inverse of its last word
	always @(addr_in or strobe_n_in) begin
		if (!strobe_n_in) begin
			mem_q = addr_in[7:0] ^ 8'h5a;
		end
	end
	// Byte held from before its capture rise until the acknowledge is seen
	always @(negedge cfg_clk_out) begin
		if (ack_in === 1'b1 && idx < N_BYTES) begin
			idx++;
		end
	end
	// Ten rises after the last byte plus one for a chained device
	always @(posedge cfg_clk_out) begin
		if (idx == N_BYTES) begin
			tail++;
		end
	end
	// Shared data pins: source byte in peripheral mode, memory otherwise
	assign data_out = run_in ? 8'(8'h3c + idx * 37) : (strobe_n_in ? ~mem_q : mem_q);
endmodule : bwl_partner

// ===== byte_wide_config_loader_tb.sv
// Self-checking bench for the loader: master up, master down and synchronous peripheral tests.
// Assumes bwl_partner models the memory and the clocked byte source.
`timescale 1ns/1ps
module byte_wide_config_loader_tb import bwl_pkg::*;;
	// --------------------
	// Signals
	// --------------------
	logic clk_sys = 1'b0;
	logic rst_n = 1'b1;
	logic [2:0] mode = MODE_PAR_UP;
	logic init_done = 1'b0;
	logic req22 = 1'b0;
	logic fast = 1'b0;
	logic load_done = 1'b0;
	logic ready = 1'b0;
	logic run = 1'b0;
	logic per_sel = 1'b0;
	logic cfg_clk, config_clock, config_clock_oe, up_oe, strobe_n, sdo, ack, ack_oe, bvalid, overrun;
	logic [7:0] data;
	logic [7:0] cfg_byte;
	logic [7:0] mon_cur;
	logic [3:0] upper;
	logic [LOW_ADDR_W-1:0] addr;
	logic [LOW_ADDR_W-1:0] mon_prev;
	logic [LOW_ADDR_W-1:0] addr_s;
	int mon_pos = 8;
	int marks = 0;
	int failures = 0;
	int total_checks = 0;

	// System clock, 40 ns period
	always #20 clk_sys = ~clk_sys;

	bwl_loader bwl_loader_i (
		.clk_sys_in(clk_sys), .rst_n_in(rst_n), .cfg_clk_in(cfg_clk),
		.mode_select_pins_in(mode), .prom_data_in(data),
		.config_clock_out(config_clock), .config_clock_oe_out(config_clock_oe),
		.prom_addr_out(addr), .upper_address_lines_out(upper),
		.upper_address_lines_oe_out(up_oe), .prom_read_strobe_n_out(strobe_n),
		.serial_pass_out(sdo), .byte_acknowledge_out(ack), .byte_acknowledge_oe_out(ack_oe),
		.init_done_in(init_done), .addr22_req_in(req22), .fast_clk_req_in(fast), .load_done_in(load_done),
		.cfg_byte_out(cfg_byte), .cfg_byte_valid_out(bvalid), .cfg_byte_ready_in(ready), .overrun_out(overrun)
	);
	bwl_partner bwl_partner_i (
		.addr_in(addr), .strobe_n_in(strobe_n), .run_in(run), .ack_in(ack),
		.cfg_clk_out(cfg_clk), .data_out(data)
	);

	// --------------------
	// Chain monitor
	// --------------------
	wire logic lclk = per_sel ? cfg_clk : config_clock;
	// Address snapshot mid-cycle, so a rise in master mode sees the address from before its own edge
	always @(negedge clk_sys) begin
		addr_s = addr;
	end
	// Next device samples pass-out on each rise; a mark is the rise after a capture
	always @(posedge lclk) begin
		if (mon_pos < 8) begin
			check("pass-out bit", 24'(sdo), 24'(mon_cur[mon_pos]));
		end
		if (per_sel ? ack === 1'b1 : addr_s !== mon_prev) begin
			if (mon_pos != 8) begin
				check("byte spacing", 24'(mon_pos), 24'h7);
			end
			mon_cur = per_sel ? 8'(8'h3c + marks * 37) : (mon_prev[7:0] ^ 8'h5a);
			mon_pos = 0;
			marks++;
		end else if (mon_pos < 8) begin
			mon_pos++;
		end
		mon_prev = addr_s;
	end

	// --------------------
	// Shared tasks
	// --------------------
	task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
		total_checks++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic complete_run();
		if (failures == 0 && total_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : complete_run

	// Inputs change one ns after the rising edge
	task automatic tick();
		@(posedge clk_sys);
		#1;
	endtask : tick

	// Bounded wait; a timeout shows up as a mismatch
	task automatic wait_val(input string what, ref logic sig, input logic v, input int lim);
		int n;
		n = 0;
		while (sig !== v && n < lim) begin
			tick();
			n++;
		end
		check(what, 24'(sig), 24'(v));
	endtask : wait_val

	task automatic take_byte(input logic [7:0] exp, input int lim);
		wait_val("byte valid", bvalid, 1'b1, lim);
		check("byte", 24'(cfg_byte), 24'(exp));
		tick();
	endtask : take_byte

	task automatic do_reset(input logic [2:0] m, input logic per);
		rst_n = 1'b0;
		mode = m;
		per_sel = per;
		req22 = 1'b0;
		fast = 1'b0;
		load_done = 1'b0;
		mon_pos = 8;
		marks = 0;
		repeat (5) tick();
		rst_n = 1'b1;
	endtask : do_reset

	// --------------------
	// Scenarios
	// --------------------
	// Count up from zero; the receiver stalls long enough to stretch the clock
	task automatic master_up();
		do_reset(MODE_PAR_UP, 1'b0);
		wait_val("read strobe", strobe_n, 1'b0, 20);
		check("start address", 24'(addr), 24'h0);
		check("upper enable", 24'(up_oe), 24'h0);
		check("clock idle", 24'(config_clock), 24'h0);
		mon_prev = addr;
		mode = MODE_SYNC_PER;
		wait_val("clock start", config_clock, 1'b1, 30);
		tick();
		check("strobe end", 24'(strobe_n), 24'h1);
		check("address step", 24'(addr), 24'h1);
		repeat (900) tick();
		ready = 1'b1;
		for (int k = 0; k < 6; k++) begin
			take_byte(8'(k) ^ 8'h5a, 300);
		end
		ready = 1'b0;
	endtask : master_up

	// Count down, widen to 22 lines and speed up mid-run, then stop
	task automatic master_down();
		do_reset(MODE_PAR_DN, 1'b0);
		wait_val("read strobe", strobe_n, 1'b0, 20);
		check("start address", 24'(addr), 24'h3ffff);
		check("clock enable", 24'(config_clock_oe), 24'h1);
		mon_prev = addr;
		ready = 1'b1;
		take_byte(8'ha5, 100);
		req22 = 1'b1;
		fast = 1'b1;
		wait_val("upper enable", up_oe, 1'b1, 300);
		check("upper lines", 24'(upper), 24'h0);
		for (int k = 1; k < 8; k++) begin
			take_byte(8'(8'hff - k) ^ 8'h5a, 300);
		end
		load_done = 1'b1;
		wait_val("clock release", config_clock_oe, 1'b0, 300);
		ready = 1'b0;
	endtask : master_down

	// External clock and bytes; five real bytes plus one caught in the trailing rises
	task automatic peripheral();
		do_reset(MODE_SYNC_PER, 1'b1);
		repeat (8) tick();
		check("ack enable", 24'(ack_oe), 24'h0);
		check("clock enable", 24'(config_clock_oe), 24'h0);
		check("read strobe", 24'(strobe_n), 24'h1);
		init_done = 1'b1;
		run = 1'b1;
		ready = 1'b1;
		for (int k = 0; k < 6; k++) begin
			take_byte(8'(8'h3c + k * 37), 100);
		end
		repeat (20) tick();
		check("ack enable", 24'(ack_oe), 24'h1);
		check("acknowledges", 24'(marks), 24'h6);
		check("overrun", 24'(overrun), 24'h0);
		run = 1'b0;
		ready = 1'b0;
	endtask : peripheral

	// Test sequence
	initial begin
		master_up();
		master_down();
		peripheral();
		complete_run();
	end
	// Tests take about 2,000 system cycles; five times that marks a hang
	initial begin
		#400000;
		failures++;
		complete_run();
	end
endmodule : byte_wide_config_loader_tb
